// ---- inc/ibp_pkg.sv ----
package ibp_pkg;
  // Bus command codes, seven bits, parity bit ignored
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_UNIV = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;
  // Switch k sits on dip_sw[k-1]; switch 8 carries weight 1
  localparam int SW_MODE = 0;
  localparam int SW_ADDR_HI = 7;
  localparam logic [4:0] DEF_ADDR = 5'h06;
  localparam int STB_SRQ = 6;
  localparam int STB_ERR = 0;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_LOWER = 8'h20;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5a;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam int NUM_SLOTS = 26;
  localparam logic [4:0] TRIG_CAT = 5'h13;
  localparam logic [7:0] TRIG_OPT_A = 8'h32;
  localparam logic [7:0] TRIG_OPT_B = 8'h33;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LISTEN_PULSE_MS = 100;
  localparam int LISTEN_PULSE_CYC = LISTEN_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 16;

  // Lines as sampled at the connector: low means asserted
  typedef struct packed {
    logic [7:0] dio_n;
    logic eoi_n;
    logic dav_n;
    logic nrfd_n;
    logic ndac_n;
    logic atn_n;
    logic ifc_n;
    logic ren_n;
  } ibp_bus_in_t;

  typedef struct packed {
    logic [7:0] dio;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic srq;
  } ibp_bus_drv_t;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } ibp_word_t;

  typedef struct packed {
    logic remote;
    logic listen;
    logic talk;
    logic lockout;
  } ibp_ind_t;

  typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_ACCEPT} ibp_ah_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_DAV} ibp_sh_t;
  typedef enum logic {P_LETTER, P_OPTION} ibp_par_t;
endpackage : ibp_pkg

// ---- verilog/ibp_fifo.sv ----
module ibp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointers wrap by overflow, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ibp_fifo_st_t;

  ibp_fifo_st_t s;
  ibp_fifo_st_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Not ready while frozen, so a producer never counts a dropped word as taken
  assign in_ready = ce && s.cnt != FULL_CNT;
  assign out_valid = s.cnt != '0;
  assign out_data = mem[s.rd];
  assign push = in_valid && in_ready;
  assign pop = ce && out_ready && out_valid;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s.wr] <= in_data;
    end
  end
endmodule : ibp_fifo

// ---- verilog/ibp_port.sv ----
// What this block does
// - Full source handshake for every sent byte
// - Full acceptor handshake for every byte offered under attention or as addressed listener
// - Talk only when addressed or talker-only
// - Take device data only when addressed listener
// - No parallel poll, controller, secondary addressing
// - Can assert service request to controller
// - Remote or local operation under bus control
// - Drive remote, listen and talk indicators
// - Lockout ignores push buttons, shows indicator
// - Switch 1 on selects addressable mode
// - Address from off switches 4-8, default 6
// - Switch 1 off: talker-only after power cycle
// - Talker-only: press measures, sends, pulses listen
// - Invalid command flags error, not executed
// - Command letters are case-insensitive
// - One slot per category, last one wins
// - Remote enable: go remote when next addressed to listen
// - Go-to-local leaves remote; lockout locks local
// - Interface clear idles talker and listener
// - Device clear restores default settings
// - Trigger command measures only in bus-trigger modes
// - Poll disable clears bit 6; poll sends status
// - Lockout cleared only by remote enable false
module ibp_port #(
  parameter int SETTLE_CYCLES = ibp_pkg::SETTLE_CYC,
  parameter int LISTEN_PULSE_CYCLES = ibp_pkg::LISTEN_PULSE_CYC,
  parameter int FIFO_DEPTH = ibp_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire ibp_pkg::ibp_bus_in_t bus_in,
  output ibp_pkg::ibp_bus_drv_t bus_out,
  output ibp_pkg::ibp_bus_drv_t bus_oe,
  input wire logic [7:0] dip_sw,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire ibp_pkg::ibp_word_t tx_word,
  input wire logic panel_press,
  output logic panel_press_ok,
  output logic meas_start,
  input wire logic srq_req,
  input wire logic [7:0] status_in,
  input wire logic [4:0] slot_sel,
  output logic [7:0] slot_val,
  output logic cmd_commit,
  output logic dev_clear,
  output logic talker_only,
  output ibp_pkg::ibp_ind_t indicators
);
  import ibp_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam int PW = $clog2(LISTEN_PULSE_CYCLES + 1);

  typedef struct packed {
    ibp_bus_in_t s1;
    ibp_bus_in_t s2;
    logic [7:0] dip1;
    logic [7:0] dip2;
    logic [1:0] cfg_cnt;
    logic cfg_done;
    logic ton;
    logic [4:0] addr;
    ibp_ah_t ah;
    ibp_sh_t sh;
    logic [CW-1:0] sh_cnt;
    logic [PW-1:0] pulse_cnt;
    ibp_word_t sh_word;
    logic sh_poll;
    logic ladr;
    logic tadr;
    logic spms;
    logic remote;
    logic lockout;
    logic rsv;
    logic err;
    ibp_par_t par;
    logic [4:0] letter;
    logic [NUM_SLOTS-1:0][7:0] slots;
    logic meas_start;
    logic dev_clear;
    logic commit;
    logic press_ok;
    ibp_bus_drv_t oe;
  } ibp_port_st_t;

  ibp_port_st_t s;
  ibp_port_st_t next_s;
  logic addressable;
  logic atn;
  logic dav;
  logic nrfd_l;
  logic ndac_l;
  logic ifc;
  logic ren;
  logic part;
  logic ah_take;
  logic talk_ok;
  logic trig_mode;
  logic spd_hit;
  logic fifo_valid;
  logic fifo_pop;
  ibp_word_t fifo_word;
  logic [7:0] rx;
  logic [6:0] cmd;
  logic [7:0] ch;
  logic [7:0] stb;
  logic is_letter;
  logic is_digit;

  // Only the second synchroniser stage is read from here on
  assign addressable = s.cfg_done && !s.ton;
  assign atn = addressable && !s.s2.atn_n;
  assign dav = !s.s2.dav_n;
  assign nrfd_l = !s.s2.nrfd_n;
  assign ndac_l = !s.s2.ndac_n;
  assign ifc = addressable && !s.s2.ifc_n;
  assign ren = !s.s2.ren_n;
  assign rx = ~s.s2.dio_n;
  assign cmd = rx[6:0];
  assign part = addressable && (atn || s.ladr);
  assign ah_take = s.ah == AH_READY && dav && part;
  assign talk_ok = addressable ? (s.tadr && !atn) : (s.cfg_done && s.ton);
  assign trig_mode = s.slots[TRIG_CAT] == TRIG_OPT_A || s.slots[TRIG_CAT] == TRIG_OPT_B;
  assign spd_hit = ah_take && atn && cmd == CMD_SPD;
  // Pop only once the byte is fully taken, so an aborted byte is resent
  assign fifo_pop = s.sh == SH_DAV && !ndac_l && talk_ok && !s.sh_poll && !ifc;

  ibp_fifo #(
    .WIDTH($bits(ibp_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  always_comb begin
    next_s = s;
    next_s.s1 = bus_in;
    next_s.s2 = s.s1;
    next_s.dip1 = dip_sw;
    next_s.dip2 = s.dip1;
    next_s.meas_start = 1'b0;
    next_s.dev_clear = 1'b0;
    next_s.commit = 1'b0;
    stb = status_in;
    stb[STB_SRQ] = s.rsv;
    stb[STB_ERR] = s.err;
    ch = rx;
    if (rx >= CH_LA && rx <= CH_LZ) begin
      ch = rx & ~CH_LOWER;
    end
    is_letter = ch >= CH_A && ch <= CH_Z;
    is_digit = ch >= CH_0 && ch <= CH_9;
    next_s.press_ok = panel_press && !s.lockout && !s.ton;
    if (s.ton && panel_press) begin
      next_s.meas_start = 1'b1;
    end
    // Straps are caught once the synchroniser has filled, never again until reset
    if (!s.cfg_done) begin
      if (s.cfg_cnt == 2'h3) begin
        next_s.cfg_done = 1'b1;
        next_s.ton = !s.dip2[SW_MODE];
        for (int i = 0; i < 5; i++) begin
          next_s.addr[i] = !s.dip2[SW_ADDR_HI-i];
        end
        if (next_s.addr == 5'h00) begin
          next_s.addr = DEF_ADDR;
        end
      end else begin
        next_s.cfg_cnt = s.cfg_cnt + 2'h1;
      end
    end
    if (!ren) begin
      next_s.remote = 1'b0;
      next_s.lockout = 1'b0;
    end
    unique case (s.ah)
      AH_IDLE: begin
        if (part) begin
          next_s.ah = AH_READY;
        end
      end
      AH_READY: begin
        if (ah_take) begin
          next_s.ah = AH_ACCEPT;
        end else if (!part) begin
          next_s.ah = AH_IDLE;
        end
      end
      AH_ACCEPT: begin
        if (!dav) begin
          next_s.ah = part ? AH_READY : AH_IDLE;
        end
      end
      default: next_s.ah = AH_IDLE;
    endcase
    if (ah_take && atn) begin
      unique case (cmd[6:5])
        GRP_LISTEN: begin
          if (cmd == CMD_UNL) begin
            next_s.ladr = 1'b0;
          end else if (cmd[4:0] == s.addr) begin
            next_s.ladr = 1'b1;
            next_s.tadr = 1'b0;
            if (ren) begin
              next_s.remote = 1'b1;
            end
          end
        end
        GRP_TALK: begin
          // Any other talk address untalks us
          next_s.tadr = cmd != CMD_UNT && cmd[4:0] == s.addr;
          // Never listen to our own bytes: they would be parsed as commands
          if (next_s.tadr) begin
            next_s.ladr = 1'b0;
          end
        end
        // Secondary addresses and parallel poll setup fall through untouched
        GRP_SECOND: ;
        GRP_UNIV: begin
          if (cmd == CMD_LLO && ren) begin
            next_s.lockout = 1'b1;
          end
          if (cmd == CMD_GTL && s.ladr) begin
            next_s.remote = 1'b0;
          end
          if (cmd == CMD_SPE) begin
            next_s.spms = 1'b1;
          end
          if (cmd == CMD_SPD) begin
            next_s.spms = 1'b0;
            next_s.rsv = 1'b0;
          end
          if (cmd == CMD_GET && s.ladr && trig_mode) begin
            next_s.meas_start = 1'b1;
          end
          if (cmd == CMD_DCL || (cmd == CMD_SDC && s.ladr)) begin
            next_s.slots = '0;
            next_s.err = 1'b0;
            next_s.par = P_LETTER;
            next_s.dev_clear = 1'b1;
          end
        end
      endcase
    end else if (ah_take && s.ladr) begin
      unique case (s.par)
        P_LETTER: begin
          if (is_letter) begin
            next_s.letter = 5'(ch - CH_A);
            next_s.par = P_OPTION;
          end else if (ch != CH_CR && ch != CH_LF && ch != CH_SP) begin
            next_s.err = 1'b1;
          end
        end
        P_OPTION: begin
          next_s.par = P_LETTER;
          if (is_letter || is_digit) begin
            next_s.slots[s.letter] = ch;
          end else begin
            next_s.err = 1'b1;
          end
        end
      endcase
      if (!s.s2.eoi_n || rx == CH_LF) begin
        next_s.commit = 1'b1;
        if (next_s.par == P_OPTION) begin
          next_s.par = P_LETTER;
          next_s.err = 1'b1;
        end
      end
    end
    if (s.pulse_cnt != '0) begin
      next_s.pulse_cnt = s.pulse_cnt - 1'b1;
    end
    unique case (s.sh)
      SH_IDLE: begin
        if (talk_ok && addressable && s.spms) begin
          next_s.sh_word = '{data: stb, eoi: 1'b0};
          next_s.sh_poll = 1'b1;
          next_s.sh = SH_SETTLE;
          next_s.sh_cnt = CW'(SETTLE_CYCLES - 1);
        end else if (talk_ok && fifo_valid) begin
          next_s.sh_word = fifo_word;
          next_s.sh_poll = 1'b0;
          next_s.sh = SH_SETTLE;
          next_s.sh_cnt = CW'(SETTLE_CYCLES - 1);
        end
      end
      SH_SETTLE: begin
        if (!talk_ok) begin
          next_s.sh = SH_IDLE;
        end else if (s.sh_cnt == '0) begin
          next_s.sh = SH_WAIT_RFD;
        end else begin
          next_s.sh_cnt = s.sh_cnt - 1'b1;
        end
      end
      SH_WAIT_RFD: begin
        if (!talk_ok) begin
          next_s.sh = SH_IDLE;
        end else if (!nrfd_l) begin
          next_s.sh = SH_DAV;
        end
      end
      SH_DAV: begin
        if (!talk_ok) begin
          next_s.sh = SH_IDLE;
        end else if (!ndac_l) begin
          next_s.sh = SH_IDLE;
          if (s.sh_poll) begin
            next_s.rsv = 1'b0;
          end
          if (s.ton) begin
            next_s.pulse_cnt = PW'(LISTEN_PULSE_CYCLES);
          end
        end
      end
    endcase
    if (ifc) begin
      next_s.ladr = 1'b0;
      next_s.tadr = 1'b0;
      next_s.ah = AH_IDLE;
      next_s.sh = SH_IDLE;
    end
    // A request in the same cycle as a clear is kept
    if (srq_req) begin
      next_s.rsv = 1'b1;
    end
    next_s.oe.ndac = next_s.ah == AH_READY;
    next_s.oe.nrfd = next_s.ah == AH_ACCEPT;
    next_s.oe.dio = next_s.sh != SH_IDLE ? next_s.sh_word.data : 8'h00;
    next_s.oe.eoi = next_s.sh != SH_IDLE && next_s.sh_word.eoi;
    next_s.oe.dav = next_s.sh == SH_DAV;
    next_s.oe.srq = next_s.rsv;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Open-collector drivers: a driven line is always pulled low
  assign bus_out = '0;
  assign bus_oe = s.oe;
  assign panel_press_ok = s.press_ok;
  assign meas_start = s.meas_start;
  assign slot_val = slot_sel < NUM_SLOTS ? s.slots[slot_sel] : 8'h00;
  assign cmd_commit = s.commit;
  assign dev_clear = s.dev_clear;
  assign talker_only = s.ton;
  assign indicators = '{
    remote: s.remote,
    listen: s.ladr || s.pulse_cnt != '0,
    talk: s.tadr || s.ton,
    lockout: s.lockout
  };

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_dav_after_rfd: assert property ($rose(bus_oe.dav) |-> $past(s.s2.nrfd_n) && $past(s.sh == SH_WAIT_RFD))
    else $error("data valid raised while not ready");
  a_dio_stable: assert property (s.sh != SH_IDLE && $past(s.sh) != SH_IDLE |-> $stable(bus_oe.dio))
    else $error("data lines changed during a byte");
  a_talk_allowed: assert property (bus_oe.dav |-> s.tadr || s.ton)
    else $error("data valid without talk permission");
  a_accept_step: assert property (ce && ah_take && !ifc |=> s.ah == AH_ACCEPT && bus_oe.nrfd && !bus_oe.ndac)
    else $error("acceptor did not take byte");
  a_listen_parse: assert property (cmd_commit |-> $past(s.ladr))
    else $error("string ended while not listener");
  a_lockout_press: assert property (s.lockout && panel_press |=> !panel_press_ok)
    else $error("press passed under lockout");
  a_mode_strap: assert property ($changed(s.ton) |-> !$past(s.cfg_done))
    else $error("talker-only changed after start");
  a_lockout_clear: assert property ($fell(s.lockout) |-> $past(s.s2.ren_n))
    else $error("lockout cleared while remote enabled");
  a_spd_clear: assert property (ce && spd_hit && !srq_req |=> !s.rsv && !bus_oe.srq)
    else $error("poll disable left service request");
  a_ifc_idle: assert property (ce && ifc |=> !s.ladr && !s.tadr && !bus_oe.dav)
    else $error("interface clear left addressed");
  a_get_mode: assert property (meas_start && !s.ton |-> $past(trig_mode))
    else $error("trigger outside bus-trigger mode");
  a_remote_ren: assert property ($rose(s.remote) |-> $past(!s.s2.ren_n) && s.ladr)
    else $error("remote entered without enable");

  c_byte_sent: cover property (bus_oe.dav ##[1:600] !bus_oe.dav);
  c_commit: cover property (cmd_commit);
  c_bus_trigger: cover property (meas_start && !s.ton);
  c_poll: cover property (s.sh_poll && bus_oe.dav);
endmodule : ibp_port

// ---- tb/ibp_ctrl_model.sv ----
module ibp_ctrl_model (
  input wire logic core_clk,
  input wire ibp_pkg::ibp_bus_in_t bus,
  output ibp_pkg::ibp_bus_drv_t drv,
  output logic atn,
  output logic ifc,
  output logic ren
);
  timeunit 1ns;
  timeprecision 100ps;
  import ibp_pkg::*;
  int hs_err = 0;

  initial begin
    drv = '0;
    atn = 1'b0;
    ifc = 1'b0;
    ren = 1'b0;
  end

  function automatic logic line_ok(input int which);
    case (which)
      0: return bus.ndac_n === 1'b0 && bus.nrfd_n === 1'b1;
      1: return bus.ndac_n === 1'b1;
      2: return bus.dav_n === 1'b0;
      default: return bus.dav_n === 1'b1;
    endcase
  endfunction : line_ok

  // Lines are looked at one step after the edge, once the device's flops have settled
  task automatic wait_line(input int which);
    int n;
    n = 0;
    while (!line_ok(which) && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 2000) hs_err++;
  endtask : wait_line

  task automatic send_byte(input logic [7:0] d, input logic e, input logic a);
    // Attention goes first so a talking device drops its byte before we free the lines
    atn = a;
    repeat (4) @(posedge core_clk);
    #1;
    drv.nrfd = 1'b0;
    drv.ndac = 1'b0;
    drv.dio = d;
    drv.eoi = e;
    wait_line(0);
    drv.dav = 1'b1;
    wait_line(1);
    drv.dav = 1'b0;
    drv.dio = '0;
    drv.eoi = 1'b0;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, output logic e, input int slow);
    // An edge apart from the previous transfer, so no line is set twice at once
    @(posedge core_clk);
    #1;
    atn = 1'b0;
    drv.ndac = 1'b1;
    drv.nrfd = 1'b0;
    wait_line(2);
    drv.nrfd = 1'b1;
    d = ~bus.dio_n;
    e = ~bus.eoi_n;
    repeat (slow) @(posedge core_clk);
    #1;
    drv.ndac = 1'b0;
    wait_line(3);
    // Keep not-ready asserted afterwards: a stalled listener, never a missing one
    drv.ndac = 1'b1;
  endtask : recv_byte
endmodule : ibp_ctrl_model

// ---- tb/tb_ibp_port.sv ----
module tb_ibp_port;
  timeunit 1ns;
  timeprecision 100ps;
  import ibp_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] dip_sw = 8'h9f;
  logic tx_valid = 1'b0;
  ibp_word_t tx_word = '0;
  logic panel_press = 1'b0;
  logic srq_req = 1'b0;
  logic [7:0] status_in = 8'h08;
  logic [4:0] slot_sel = 5'h00;
  ibp_bus_in_t bus_in;
  ibp_bus_drv_t bus_out;
  ibp_bus_drv_t bus_oe;
  ibp_bus_drv_t m_drv;
  logic m_atn;
  logic m_ifc;
  logic m_ren;
  logic tx_ready;
  logic panel_press_ok;
  logic meas_start;
  logic [7:0] slot_val;
  logic cmd_commit;
  logic dev_clear;
  logic talker_only;
  ibp_ind_t indicators;
  int fails = 0;
  int cmp_count = 0;
  int n_commit = 0;
  int n_meas = 0;
  int n_clr = 0;
  int n_ok = 0;
  logic [7:0] rd;
  logic re;
  string s;

  // Open-collector wire: low when any party pulls, pulled up otherwise
  assign bus_in = '{dio_n: ~(m_drv.dio | bus_oe.dio), eoi_n: ~(m_drv.eoi | bus_oe.eoi),
    dav_n: ~(m_drv.dav | bus_oe.dav), nrfd_n: ~(m_drv.nrfd | bus_oe.nrfd),
    ndac_n: ~(m_drv.ndac | bus_oe.ndac), atn_n: ~m_atn, ifc_n: ~m_ifc, ren_n: ~m_ren};

  ibp_port #(.SETTLE_CYCLES(4), .LISTEN_PULSE_CYCLES(20), .FIFO_DEPTH(16)) dut_u (
    .core_clk(core_clk), .srst(srst), .ce(ce), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .dip_sw(dip_sw), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .panel_press(panel_press), .panel_press_ok(panel_press_ok),
    .meas_start(meas_start), .srq_req(srq_req), .status_in(status_in), .slot_sel(slot_sel),
    .slot_val(slot_val), .cmd_commit(cmd_commit), .dev_clear(dev_clear),
    .talker_only(talker_only), .indicators(indicators));

  ibp_ctrl_model model_u (.core_clk(core_clk), .bus(bus_in), .drv(m_drv), .atn(m_atn),
    .ifc(m_ifc), .ren(m_ren));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (cmd_commit === 1'b1) n_commit++;
    if (meas_start === 1'b1) n_meas++;
    if (dev_clear === 1'b1) n_clr++;
    if (panel_press_ok === 1'b1) n_ok++;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic cmd(input logic [7:0] b);
    model_u.send_byte(b, 1'b0, 1'b1);
    idle(2);
  endtask : cmd

  task automatic press;
    panel_press = 1'b1;
    idle(1);
    panel_press = 1'b0;
    idle(3);
  endtask : press

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    idle(3);
    chk("oe in reset", 16'(bus_oe), 16'h0000);
    chk("bus_out", 16'(bus_out), 16'h0000);
    chk("ind in reset", 16'(indicators), 16'h0000);
    chk("tx_ready in reset", 16'(tx_ready), 16'h0001);
    idle(9);
    srst = 1'b0;
    idle(10);
    chk("talker_only", 16'(talker_only), 16'h0000);
    model_u.ren = 1'b1;
    idle(4);
    chk("remote before addr", 16'(indicators.remote), 16'h0000);
    cmd(8'h26);
    chk("listen", 16'(indicators.listen), 16'h0001);
    chk("remote", 16'(indicators.remote), 16'h0001);
    s = "a1t2A5b";
    for (int i = 0; i < s.len(); i++) begin
      model_u.send_byte(s[i], 1'(i == s.len() - 1), 1'b0);
    end
    idle(3);
    chk("commit", 16'(n_commit), 16'h0001);
    chk("slot A", 16'(slot_val), 16'h0035);
    slot_sel = 5'h13;
    idle(1);
    chk("slot T", 16'(slot_val), 16'h0032);
    slot_sel = 5'h01;
    idle(1);
    chk("slot B", 16'(slot_val), 16'h0000);
    slot_sel = 5'h00;
    cmd(8'h08);
    chk("trigger", 16'(n_meas), 16'h0001);
    press();
    chk("press ok", 16'(n_ok), 16'h0001);
    cmd(8'h11);
    chk("lockout", 16'(indicators.lockout), 16'h0001);
    press();
    chk("press locked", 16'(n_ok), 16'h0001);
    cmd(8'h01);
    chk("gtl remote", 16'(indicators.remote), 16'h0000);
    chk("gtl lockout", 16'(indicators.lockout), 16'h0001);
    ce = 1'b0;
    srq_req = 1'b1;
    idle(1);
    srq_req = 1'b0;
    chk("ce ready", 16'(tx_ready), 16'h0000);
    idle(2);
    chk("ce frozen", 16'(bus_oe.srq), 16'h0000);
    ce = 1'b1;
    srq_req = 1'b1;
    idle(1);
    srq_req = 1'b0;
    idle(2);
    chk("srq line", 16'(bus_oe.srq), 16'h0001);
    cmd(8'h18);
    cmd(8'h46);
    model_u.recv_byte(rd, re, 0);
    chk("poll byte", 16'(rd), 16'h0049);
    chk("poll eoi", 16'(re), 16'h0000);
    idle(2);
    chk("srq cleared", 16'(bus_oe.srq), 16'h0000);
    cmd(8'h19);
    tx_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      tx_word = '{data: 8'(i + 8'h40), eoi: 1'(i == 15)};
      idle(1);
    end
    tx_valid = 1'b0;
    chk("fifo full", 16'(tx_ready), 16'h0000);
    idle(8);
    chk("no talk under atn", 16'(bus_oe.dav), 16'h0000);
    for (int i = 0; i < 16; i++) begin
      model_u.recv_byte(rd, re, (i == 0) ? 12 : 0);
      chk("talk data", 16'(rd), 16'(i + 8'h40));
      chk("talk eoi", 16'(re), 16'(i == 15));
      chk("talk ind", 16'(indicators.talk), 16'h0001);
    end
    idle(10);
    chk("fifo empty", 16'(tx_ready), 16'h0001);
    chk("drained dav", 16'(bus_oe.dav), 16'h0000);
    model_u.ifc = 1'b1;
    idle(4);
    model_u.ifc = 1'b0;
    idle(3);
    chk("ifc talk", 16'(indicators.talk), 16'h0000);
    chk("ifc listen", 16'(indicators.listen), 16'h0000);
    cmd(8'h14);
    chk("dev clear", 16'(n_clr), 16'h0001);
    chk("slot A cleared", 16'(slot_val), 16'h0000);
    model_u.ren = 1'b0;
    idle(6);
    chk("ren off lockout", 16'(indicators.lockout), 16'h0000);
    dip_sw = 8'h9e;
    idle(6);
    chk("mode held", 16'(talker_only), 16'h0000);
    srst = 1'b1;
    idle(3);
    srst = 1'b0;
    idle(8);
    chk("ton mode", 16'(talker_only), 16'h0001);
    chk("ton talk ind", 16'(indicators.talk), 16'h0001);
    press();
    chk("ton measure", 16'(n_meas), 16'h0002);
    chk("ton no press ok", 16'(n_ok), 16'h0001);
    tx_word = '{data: 8'h37, eoi: 1'b1};
    tx_valid = 1'b1;
    idle(1);
    tx_valid = 1'b0;
    model_u.recv_byte(rd, re, 0);
    chk("ton data", 16'(rd), 16'h0037);
    chk("ton eoi", 16'(re), 16'h0001);
    chk("ton pulse", 16'(indicators.listen), 16'h0001);
    idle(24);
    chk("ton pulse end", 16'(indicators.listen), 16'h0000);
    chk("handshake waits", 16'(model_u.hs_err), 16'h0000);
    close_out();
  end
endmodule : tb_ibp_port
